// [logic/twb_consts.vh]
// constants for the two-wire bus protocol engine
// Functional notes
// R1: only seven bit addressing, no ten bit
// R2: standard and fast bit rates supported
// R3: lines driven low or released only
// R4: bus free when high, busy start-stop
// R5: master makes all clocks, start, stop
// R6: master begins only on free bus
// R7: start/stop are data edges, clock high
// R8: data changes only while clock low
// R9: nine clocks per byte, msb first
// R10: sender releases data, samples ack ninth
// R11: receiver may stretch clock after ninth
// R12: receiver pulls data low for ack
// R13: unacked address leaves data high
// R14: master receiver nacks last byte
// R15: first byte is address plus direction
// R16: repeated start without stop allowed
// R17: after stop drop mastership, not addressed
// R18: watch own and general call addresses
// R19: address zero is general call only
// R20: driving high reading low loses arbitration
// R21: lost arbitration becomes slave, releases data
// R22: lost master clocks to byte end
// R23: count high only after clock seen high
`ifndef TWB_CONSTS_VH
`define TWB_CONSTS_VH
`define TWB_CLK_HZ 40000000
`define TWB_STD_BPS 100000
`define TWB_FAST_BPS 400000
`define TWB_HALF_STD ((`TWB_CLK_HZ / `TWB_STD_BPS) / 2)
`define TWB_HALF_FAST ((`TWB_CLK_HZ / `TWB_FAST_BPS) / 2)
`define TWB_GC_ADDR 7'h00
`define TWB_CMD_START 3'h1
`define TWB_CMD_WRITE 3'h2
`define TWB_CMD_READ 3'h3
`define TWB_CMD_STOP 3'h4
`endif

// [logic/twb_line_sync.v]
// two flip-flop synchroniser with edge detection for both bus lines
module twb_line_sync (
    input wire core_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg scl_s,
    output reg sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);
    reg scl_m_reg;
    reg sda_m_reg;
    reg scl_d_reg;
    reg sda_d_reg;

    always @(posedge core_clk) begin
        if (rst) begin
            scl_m_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_m_reg <= scl_in;
            sda_m_reg <= sda_in;
            scl_s <= scl_m_reg;
            sda_s <= sda_m_reg;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // see R7
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // see R7
endmodule

// [logic/twb_engine.v]
// two-wire bus protocol engine: master, slave, general call, arbitration
`include "twb_consts.vh"
module twb_engine #(
    parameter HALF_STD = `TWB_HALF_STD,
    parameter HALF_FAST = `TWB_HALF_FAST
) (
    input wire core_clk,
    input wire rst,
    input wire bus_interface_enable,
    input wire general_call_enable,
    input wire [6:0] own_address_register,
    input wire fast_mode,
    input wire ack_enable,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire [6:0] target_slave_address,
    input wire cmd_dir_read,
    input wire [7:0] cmd_data,
    input wire cmd_last,
    output wire cmd_ready,
    output reg done_pulse_reg,
    output reg [7:0] rx_data_reg,
    output reg ack_seen_reg,
    output reg arb_lost_reg,
    output reg addr_match_reg,
    output reg gc_match_reg,
    output reg slave_read_reg,
    output reg bus_busy_reg,
    output reg master_reg,
    input wire [7:0] slave_tx_data,
    output reg slave_byte_reg,
    input wire serial_clock_pin_in,
    output wire serial_clock_pin_out,
    output wire serial_clock_pin_oe,
    input wire serial_data_pin_in,
    output wire serial_data_pin_out,
    output wire serial_data_pin_oe
);
    // ----------------------------------------
    // master states
    // ----------------------------------------
    localparam M_IDLE = 4'h0;
    localparam M_START_A = 4'h1;
    localparam M_START_B = 4'h2;
    localparam M_LOW = 4'h3;
    localparam M_HIGH = 4'h4;
    localparam M_HOLD = 4'h5;
    localparam M_STOP_A = 4'h6;
    localparam M_STOP_B = 4'h7;
    localparam M_STOP_C = 4'h8;
    localparam M_RS_A = 4'h9;

    // ----------------------------------------
    // slave states
    // ----------------------------------------
    localparam S_IDLE = 2'h0;
    localparam S_ADDR = 2'h1;
    localparam S_RX = 2'h2;
    localparam S_TX = 2'h3;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    twb_line_sync twb_line_sync_i (
        .core_clk(core_clk),
        .rst(rst),
        .scl_in(serial_clock_pin_in),
        .sda_in(serial_data_pin_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    reg [3:0] mst_reg;
    reg [2:0] cmd_reg;
    reg [8:0] mshift_reg;
    reg [3:0] mbit_reg;
    reg [9:0] cnt_reg;
    reg m_scl_low_reg;
    reg m_sda_low_reg;
    reg m_lost_reg;
    reg m_rd_reg;
    reg [1:0] sst_reg;
    reg [7:0] sshift_reg;
    reg [3:0] sbit_reg;
    reg s_sda_low_reg;
    reg s_scl_low_reg;
    reg s_nack_reg;

    // half period count chosen per bit rate, see R2
    wire [9:0] half = fast_mode ? HALF_FAST[9:0] : HALF_STD[9:0];
    wire cnt_done = (cnt_reg >= half - 10'h001);

    assign cmd_ready = bus_interface_enable && (mst_reg == M_IDLE || mst_reg == M_HOLD) &&
        !(mst_reg == M_IDLE && (bus_busy_reg || !scl_s || !sda_s)); // see R6

    // open drain: only pull low or release, see R3
    assign serial_clock_pin_out = 1'b0;
    assign serial_data_pin_out = 1'b0;
    assign serial_clock_pin_oe = m_scl_low_reg | s_scl_low_reg; // see R3
    assign serial_data_pin_oe = m_sda_low_reg | s_sda_low_reg; // see R3

    // ----------------------------------------
    // bus free and busy tracking
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (rst || !bus_interface_enable) begin
            bus_busy_reg <= 1'b0;
        end else if (start_det) begin
            bus_busy_reg <= 1'b1; // see R4
        end else if (stop_det) begin
            bus_busy_reg <= 1'b0; // see R4
        end
    end

    // ----------------------------------------
    // master sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (rst || !bus_interface_enable) begin
            mst_reg <= M_IDLE;
            cmd_reg <= 3'h0;
            mshift_reg <= 9'h1FF;
            mbit_reg <= 4'h0;
            cnt_reg <= 10'h000;
            m_scl_low_reg <= 1'b0;
            m_sda_low_reg <= 1'b0;
            m_lost_reg <= 1'b0;
            m_rd_reg <= 1'b0;
            master_reg <= 1'b0;
            done_pulse_reg <= 1'b0;
            rx_data_reg <= 8'h00;
            ack_seen_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
        end else begin
            done_pulse_reg <= 1'b0;
            cnt_reg <= cnt_done ? 10'h000 : cnt_reg + 10'h001;
            case (mst_reg)
                M_IDLE: begin
                    m_scl_low_reg <= 1'b0;
                    m_sda_low_reg <= 1'b0;
                    if (cmd_valid && cmd_ready && cmd_code == `TWB_CMD_START) begin
                        mst_reg <= M_START_A;
                        master_reg <= 1'b1;
                        arb_lost_reg <= 1'b0;
                        cnt_reg <= 10'h000;
                    end
                end
                M_START_A: begin
                    if (cnt_done) begin
                        m_sda_low_reg <= 1'b1; // see R7
                        mst_reg <= M_START_B;
                    end
                end
                M_START_B: begin
                    if (cnt_done) begin
                        m_scl_low_reg <= 1'b1; // see R5
                        done_pulse_reg <= 1'b1;
                        mst_reg <= M_HOLD;
                    end
                end
                M_HOLD: begin
                    // clock held low while awaiting next command
                    cnt_reg <= 10'h000;
                    if (cmd_valid) begin
                        cmd_reg <= cmd_code;
                        mbit_reg <= 4'h0;
                        if (cmd_code == `TWB_CMD_WRITE) begin
                            m_rd_reg <= 1'b0;
                            // address byte carries direction bit, see R15 R1
                            mshift_reg <= {cmd_data, 1'b1}; // see R10
                            mst_reg <= M_LOW;
                        end else if (cmd_code == `TWB_CMD_READ) begin
                            m_rd_reg <= 1'b1;
                            mshift_reg <= {8'hFF, cmd_last}; // see R14
                            mst_reg <= M_LOW;
                        end else if (cmd_code == `TWB_CMD_STOP) begin
                            mst_reg <= M_STOP_A;
                        end else begin
                            mst_reg <= M_RS_A; // see R16
                        end
                    end
                end
                M_LOW: begin
                    m_scl_low_reg <= 1'b1;
                    // data changes only with clock low, see R8
                    m_sda_low_reg <= ~mshift_reg[8] & ~m_lost_reg; // see R9
                    if (cnt_done) begin
                        m_scl_low_reg <= 1'b0;
                        mst_reg <= M_HIGH;
                    end
                end
                M_HIGH: begin
                    // wait for the line to be seen high, stretch extends, see R23 R11
                    if (!scl_s) begin
                        cnt_reg <= 10'h000;
                    end else if (cnt_done) begin
                        if (mshift_reg[8] && !sda_s && !m_lost_reg &&
                            !(m_rd_reg && mbit_reg != 4'h8) &&
                            !(!m_rd_reg && mbit_reg == 4'h8)) begin
                            m_lost_reg <= 1'b1; // see R20 R22
                            arb_lost_reg <= 1'b1; // see R21
                            m_sda_low_reg <= 1'b0; // see R21
                        end
                        if (mbit_reg < 4'h8) begin
                            rx_data_reg <= {rx_data_reg[6:0], sda_s};
                        end else begin
                            ack_seen_reg <= ~sda_s; // see R10 R12
                        end
                        mshift_reg <= {mshift_reg[7:0], 1'b1};
                        m_scl_low_reg <= 1'b1;
                        if (mbit_reg == 4'h8) begin
                            done_pulse_reg <= 1'b1;
                            // lost master keeps clocking only to byte end, see R22
                            mst_reg <= m_lost_reg ? M_IDLE : M_HOLD;
                            master_reg <= ~m_lost_reg;
                            m_lost_reg <= 1'b0; // ack level kept, freed later with clock low, see R8
                        end else begin
                            mbit_reg <= mbit_reg + 4'h1;
                            mst_reg <= M_LOW;
                        end
                    end
                end
                M_RS_A: begin
                    // release data with clock low, then redo start, see R16
                    m_sda_low_reg <= 1'b0;
                    if (cnt_done) begin
                        m_scl_low_reg <= 1'b0;
                        if (scl_s) begin
                            mst_reg <= M_START_A;
                        end
                    end
                end
                M_STOP_A: begin
                    m_sda_low_reg <= 1'b1;
                    if (cnt_done) begin
                        m_scl_low_reg <= 1'b0;
                        mst_reg <= M_STOP_B;
                    end
                end
                M_STOP_B: begin
                    if (!scl_s) begin
                        cnt_reg <= 10'h000;
                    end else if (cnt_done) begin
                        m_sda_low_reg <= 1'b0; // see R7 R5
                        mst_reg <= M_STOP_C;
                    end
                end
                M_STOP_C: begin
                    if (cnt_done) begin
                        master_reg <= 1'b0; // see R17
                        done_pulse_reg <= 1'b1;
                        mst_reg <= M_IDLE;
                    end
                end
                default: begin
                    mst_reg <= M_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // slave address watcher and byte engine
    // ----------------------------------------
    // general call never taken as ordinary address, see R19
    wire own_hit = (sshift_reg[7:1] == own_address_register) &&
        (own_address_register != `TWB_GC_ADDR);
    wire gc_hit = general_call_enable && (sshift_reg == 8'h00); // see R19
    wire slave_ok = !master_reg || m_lost_reg; // see R21

    always @(posedge core_clk) begin
        if (rst || !bus_interface_enable) begin
            sst_reg <= S_IDLE;
            sshift_reg <= 8'h00;
            sbit_reg <= 4'h0;
            s_sda_low_reg <= 1'b0;
            s_scl_low_reg <= 1'b0;
            s_nack_reg <= 1'b0;
            addr_match_reg <= 1'b0;
            gc_match_reg <= 1'b0;
            slave_read_reg <= 1'b0;
            slave_byte_reg <= 1'b0;
        end else begin
            slave_byte_reg <= 1'b0;
            s_scl_low_reg <= 1'b0;
            if (stop_det) begin
                sst_reg <= S_IDLE; // see R17
                s_sda_low_reg <= 1'b0;
                addr_match_reg <= 1'b0;
                gc_match_reg <= 1'b0;
            end else if (start_det) begin
                sst_reg <= S_ADDR; // see R18
                sbit_reg <= 4'hF; // clock fall of the start itself wraps this to zero
                s_sda_low_reg <= 1'b0;
                addr_match_reg <= 1'b0;
                gc_match_reg <= 1'b0;
            end else if (scl_rise && sbit_reg < 4'h8) begin
                sshift_reg <= {sshift_reg[6:0], sda_s};
            end else if (scl_rise && sst_reg == S_TX) begin
                s_nack_reg <= sda_s; // see R14
            end else if (scl_fall && sst_reg != S_IDLE) begin
                if (sbit_reg == 4'h7) begin
                    sbit_reg <= 4'h8;
                    if (sst_reg == S_ADDR && slave_ok && ack_enable && (own_hit || gc_hit)) begin
                        s_sda_low_reg <= 1'b1; // see R12
                        addr_match_reg <= 1'b1; // see R18
                        gc_match_reg <= gc_hit;
                        slave_read_reg <= sshift_reg[0] & ~gc_hit; // see R15
                    end else if (sst_reg == S_RX && ack_enable) begin
                        s_sda_low_reg <= 1'b1; // see R12
                    end else if (sst_reg == S_ADDR) begin
                        s_sda_low_reg <= 1'b0; // see R13
                        sst_reg <= S_IDLE;
                    end else begin
                        s_sda_low_reg <= 1'b0;
                    end
                end else if (sbit_reg == 4'h8) begin
                    sbit_reg <= 4'h0;
                    slave_byte_reg <= (sst_reg != S_ADDR) || addr_match_reg;
                    if (sst_reg == S_ADDR) begin
                        sst_reg <= slave_read_reg ? S_TX : S_RX;
                        sshift_reg <= slave_tx_data;
                        s_sda_low_reg <= slave_read_reg & ~slave_tx_data[7];
                    end else if (sst_reg == S_TX && !s_nack_reg) begin
                        sshift_reg <= slave_tx_data;
                        s_sda_low_reg <= ~slave_tx_data[7]; // see R9
                    end else if (sst_reg == S_TX) begin
                        // nack from master receiver ends this slave, see R14
                        sst_reg <= S_IDLE;
                        s_sda_low_reg <= 1'b0;
                    end else if (!s_sda_low_reg) begin
                        sst_reg <= S_IDLE;
                    end else begin
                        s_sda_low_reg <= 1'b0;
                    end
                end else begin
                    sbit_reg <= sbit_reg + 4'h1;
                    if (sst_reg == S_TX) begin
                        // drive next bit only with clock low, see R8
                        s_sda_low_reg <= ~sshift_reg[6];
                        sshift_reg <= {sshift_reg[6:0], 1'b1};
                    end
                end
            end
        end
    end
endmodule

// [testbench/twb_engine_properties.sv]
// checker: timing relations at the two-wire engine ports
`include "twb_consts.vh"
module twb_engine_properties (
    input wire core_clk,
    input wire rst,
    input wire bus_interface_enable,
    input wire [2:0] cmd_code,
    input wire cmd_ready,
    input wire done_pulse_reg,
    input wire arb_lost_reg,
    input wire addr_match_reg,
    input wire gc_match_reg,
    input wire bus_busy_reg,
    input wire master_reg,
    input wire serial_clock_pin_in,
    input wire serial_clock_pin_out,
    input wire serial_clock_pin_oe,
    input wire serial_data_pin_in,
    input wire serial_data_pin_out,
    input wire serial_data_pin_oe
);
    // --------------------
    // assertions
    // --------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    pins_low_a: assert property (!serial_clock_pin_out && !serial_data_pin_out)
        else $error("pin driven high");
    idle_release_a: assert property (!bus_interface_enable [*2] |->
        !serial_clock_pin_oe && !serial_data_pin_oe) else $error("disabled but driving");
    reset_release_a: assert property (disable iff (1'b0) rst |=>
        !serial_clock_pin_oe && !serial_data_pin_oe) else $error("driving after reset");
    // sync flops delay the view of the lines, hence the windows
    start_busy_a: assert property (bus_interface_enable && $fell(serial_data_pin_in)
        && serial_clock_pin_in |-> ##[1:8] bus_busy_reg) else $error("start not seen");
    stop_free_a: assert property (bus_interface_enable && $rose(serial_data_pin_in)
        && serial_clock_pin_in |-> ##[1:8] !bus_busy_reg) else $error("stop not seen");
    stop_master_a: assert property ($rose(serial_data_pin_in) && serial_clock_pin_in
        |-> ##[1:16] !master_reg) else $error("mastership kept after stop");
    free_start_a: assert property (cmd_ready && cmd_code == `TWB_CMD_START && !master_reg
        |-> !bus_busy_reg) else $error("start offered on busy bus");
    slave_stable_a: assert property (!master_reg && (addr_match_reg || gc_match_reg)
        && serial_clock_pin_in && $past(serial_clock_pin_in) |-> $stable(serial_data_pin_oe))
        else $error("slave data moved in clock high");
    arb_release_a: assert property ($rose(arb_lost_reg) |-> !serial_data_pin_oe [*3])
        else $error("data held after lost arbitration");
    done_single_a: assert property (done_pulse_reg |=> !done_pulse_reg)
        else $error("done longer than one cycle");
    cover property ($rose(arb_lost_reg));
    cover property ($rose(addr_match_reg));
    cover property ($rose(gc_match_reg));
endmodule

bind twb_engine twb_engine_properties twb_engine_properties_i (.core_clk, .rst,
    .bus_interface_enable, .cmd_code, .cmd_ready, .done_pulse_reg, .arb_lost_reg,
    .addr_match_reg, .gc_match_reg, .bus_busy_reg, .master_reg, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_pin_in, .serial_data_pin_out,
    .serial_data_pin_oe);

// [testbench/twb_far_end.sv]
// far-side model: slave at a fixed address plus a simple second master
module twb_far_end #(
    parameter logic [6:0] slave_addr = 7'h50
) (
    input wire scl,
    input wire sda,
    input wire [7:0] tx_byte,
    output logic scl_low,
    output wire sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b0;
    logic hold = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic first = 1'b0;
    logic mnack = 1'b0;
    logic slv_low = 1'b0;
    logic m_sda = 1'b0;
    logic [7:0] sh = 8'h00;
    int cnt = 9;
    initial scl_low = 1'b0;
    // only ever pulls low; hold plays a rival master
    assign sda_low = slv_low | m_sda | hold;
    // --------------------
    // slave side
    // --------------------
    always @(negedge sda) if (scl && !drv) begin
        cnt = 9;
        first = 1'b1;
        sel = 1'b0;
        slv_low = 1'b0;
    end
    always @(posedge sda) if (scl && !drv) sel = 1'b0;
    always @(posedge scl) if (!drv) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else mnack = sda;
    end
    always @(negedge scl) if (!drv) begin
        slv_low = 1'b0;
        if (cnt == 9) cnt = 0;
        else begin
            if (cnt == 7 && first) begin
                sel = (sh[7:1] == slave_addr);
                rd = sh[0];
            end
            if (cnt == 7) slv_low = sel && (first || !rd);
            if (cnt == 8) begin
                if (rd && !first && mnack) sel = 1'b0;
                first = 1'b0;
            end
            cnt = (cnt == 8) ? 0 : cnt + 1;
            if (sel && rd && !first && cnt < 8) slv_low = !tx_byte[7 - cnt];
        end
    end
    // --------------------
    // master side, 200 ns clock
    // --------------------
    task automatic pulse(input logic d, output logic s);
        #50 m_sda = d;
        #50 scl_low = 1'b0;
        wait (scl);
        #50 s = sda;
        #50 scl_low = 1'b1;
    endtask
    task automatic p_start;
        drv = 1'b1;
        #100 m_sda = 1'b1;
        #100 scl_low = 1'b1;
    endtask
    task automatic p_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(!b[i], s);
        pulse(1'b0, s);
        ack = !s;
    endtask
    task automatic p_stop;
        drv = 1'b1;
        scl_low = 1'b1;
        #50 m_sda = 1'b1;
        hold = 1'b0;
        #50 scl_low = 1'b0;
        wait (scl);
        #100 m_sda = 1'b0;
        #100 drv = 1'b0;
    endtask
endmodule

// [testbench/tb_two_wire_bus_protocol_engine.sv]
// testbench: two-wire engine against the far-side bus model
`include "twb_consts.vh"
module tb_two_wire_bus_protocol_engine;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] PEER = 7'h50;
    localparam logic [19:0] NONE = 20'h00000;
    localparam logic [19:0] ACK = 20'h40100;
    localparam logic [19:0] NACK = 20'h40000;
    localparam logic [19:0] ARB = 20'h80200;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_interface_enable = 1'b0;
    logic general_call_enable = 1'b0;
    logic [6:0] own_address_register = 7'h01;
    logic fast_mode = 1'b1;
    logic ack_enable = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_code = 3'h0;
    logic [6:0] target_slave_address = 7'h00;
    logic cmd_dir_read = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_last = 1'b0;
    logic [7:0] slave_tx_data = 8'h00;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] d;
    logic a;
    wire cmd_ready, done_pulse_reg, ack_seen_reg, arb_lost_reg, addr_match_reg, gc_match_reg;
    wire slave_read_reg, bus_busy_reg, master_reg, slave_byte_reg, p_scl, p_sda;
    wire serial_clock_pin_out, serial_clock_pin_oe, serial_data_pin_out, serial_data_pin_oe;
    wire [7:0] rx_data_reg;
    wire scl = (serial_clock_pin_oe ? serial_clock_pin_out : 1'b1) && !p_scl;
    wire sda = (serial_data_pin_oe ? serial_data_pin_out : 1'b1) && !p_sda;
    logic [19:0] expq[$];
    int bad_count = 0;
    int total_checks = 0;
    always #12.5 core_clk = ~core_clk;
    // short half periods keep the run brief
    twb_engine #(.HALF_STD(4), .HALF_FAST(2)) twb_engine_i (.core_clk, .rst,
        .bus_interface_enable, .general_call_enable, .own_address_register, .fast_mode,
        .ack_enable, .cmd_valid, .cmd_code, .target_slave_address, .cmd_dir_read, .cmd_data,
        .cmd_last, .cmd_ready, .done_pulse_reg, .rx_data_reg, .ack_seen_reg, .arb_lost_reg,
        .addr_match_reg, .gc_match_reg, .slave_read_reg, .bus_busy_reg, .master_reg,
        .slave_tx_data, .slave_byte_reg, .serial_clock_pin_in(scl), .serial_clock_pin_out,
        .serial_clock_pin_oe, .serial_data_pin_in(sda), .serial_data_pin_out,
        .serial_data_pin_oe);
    twb_far_end #(.slave_addr(PEER)) twb_far_end_i (.scl, .sda, .tx_byte(peer_tx),
        .scl_low(p_scl), .sda_low(p_sda));
    // --------------------
    // compare and drive
    // --------------------
    task automatic cmp_byte(input logic [19:0] e, input logic [9:0] got);
        total_checks++;
        if (((got ^ e[9:0]) & e[19:10]) !== 10'h000) begin
            bad_count++;
            $display("MISMATCH %0t byte result %h expected %h", $time, got, e[9:0]);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [7:0] b, input logic l,
            input logic [19:0] e);
        int n;
        expq.push_back(e);
        cmd_code <= c;
        cmd_data <= b;
        cmd_last <= l;
        target_slave_address <= b[7:1];
        cmd_dir_read <= b[0];
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(posedge core_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 5000 && done_pulse_reg !== 1'b1; n++) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (done_pulse_reg === 1'b1) begin
            if (expq.size() == 0) cmp_flag(1'b1, 1'b0);
            else cmp_byte(expq.pop_front(), {arb_lost_reg, ack_seen_reg, rx_data_reg});
        end
    end
    task automatic end_of_test;
        if (expq.size() != 0) $display("MISMATCH %0t %0d results missing", $time, expq.size());
        bad_count += expq.size();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // --------------------
    // tests
    // --------------------
    initial begin
        void'($urandom(58));
        d = 8'($urandom());
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        own_address_register <= 7'h20 | 7'($urandom() % 16);
        peer_tx <= 8'($urandom());
        slave_tx_data <= 8'($urandom());
        repeat (2) @(posedge core_clk);
        bus_interface_enable <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp_flag(bus_busy_reg | serial_data_pin_oe | serial_clock_pin_oe, 1'b0);
        $display("test reset done");
        cmd(`TWB_CMD_START, 8'h00, 1'b0, NONE);
        cmd(`TWB_CMD_WRITE, {PEER, 1'b0}, 1'b0, ACK);
        cmd(`TWB_CMD_WRITE, d, 1'b0, ACK);
        cmd(`TWB_CMD_START, 8'h00, 1'b0, NONE);
        cmd(`TWB_CMD_WRITE, {PEER, 1'b1}, 1'b0, ACK);
        cmd(`TWB_CMD_READ, 8'h00, 1'b0, {10'h0FF, 2'b00, peer_tx});
        cmd(`TWB_CMD_READ, 8'h00, 1'b1, {10'h0FF, 2'b00, peer_tx});
        cmd(`TWB_CMD_STOP, 8'h00, 1'b0, NONE);
        repeat (8) @(posedge core_clk);
        cmp_flag(bus_busy_reg | master_reg, 1'b0);
        $display("test master write read done");
        fast_mode <= 1'b0;
        cmd(`TWB_CMD_START, 8'h00, 1'b0, NONE);
        cmd(`TWB_CMD_WRITE, {PEER ^ 7'h01, 1'b0}, 1'b0, NACK);
        cmd(`TWB_CMD_STOP, 8'h00, 1'b0, NONE);
        repeat (8) @(posedge core_clk);
        $display("test no acknowledge done");
        // own address with and without ack, general call enabled and not
        for (int i = 0; i < 4; i++) begin
            general_call_enable <= i[1] & ~i[0];
            ack_enable <= ~i[0] | i[1];
            @(negedge core_clk);
            twb_far_end_i.p_start();
            twb_far_end_i.p_byte(i[1] ? 8'h00 : {own_address_register, 1'b0}, a);
            cmp_flag(a, ~i[0]);
            cmp_flag(i[1] ? gc_match_reg : addr_match_reg, ~i[0]);
            cmp_flag(slave_read_reg, 1'b0);
            twb_far_end_i.p_stop();
            repeat (8) @(posedge core_clk);
            cmp_flag(addr_match_reg | gc_match_reg | bus_busy_reg, 1'b0);
        end
        $display("test slave addressing done");
        general_call_enable <= 1'b0;
        fast_mode <= 1'b1;
        cmd(`TWB_CMD_START, 8'h00, 1'b0, NONE);
        twb_far_end_i.hold <= 1'b1;
        cmd(`TWB_CMD_WRITE, 8'h80 | d, 1'b0, ARB);
        twb_far_end_i.p_stop();
        repeat (8) @(posedge core_clk);
        cmp_flag(bus_busy_reg | master_reg, 1'b0);
        $display("test arbitration done");
        end_of_test();
    end
    // whole run is well under 100 us; this margin only catches a hang
    initial begin
        #1ms;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
